// file: hdl/bilc_loader.sv
// boot loader sequencer with control register and record routing
`timescale 1ns/1ps
module bilc_loader
  import bilc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic strapPin,
  input wire logic [1:0] progLevel,
  input wire logic user_continue_setting,
  input wire logic recValid,
  input wire bilc_rec_t rec,
  output logic recReady,
  output logic srcRewind,
  output logic imageEnd,
  input wire logic imageEmpty,
  output logic xramWrEn,
  output bilc_wr_t xramWr,
  output logic iramWrEn,
  output logic [7:0] iramAddr,
  output logic [7:0] iramData,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  output logic cpuRelease,
  output logic cpuJump,
  output logic [15:0] cpuJumpAddr
);
  typedef enum logic [2:0] {ST_STRAP, ST_FACTORY, ST_USER, ST_STATUS, ST_DONE} bilc_state_t;
  bilc_state_t state;
  bilc_state_t next_state;
  logic [7:0] ctrl;
  logic [7:0] status;
  logic strapMeta;
  logic strapSync;
  logic firstBlock;
  logic stickyFactOnly;
  logic [7:0] next_status;
  // ***************************************************************
  // strap synchroniser
  // ***************************************************************
  // two stages before use; kept out of reset so the pin level is settled
  // when the first state after release captures it (reset must last two clocks)
  always_ff @(posedge clk) begin
    strapMeta <= strapPin;
    strapSync <= strapMeta;
  end
  // ***************************************************************
  // decoding
  // ***************************************************************
  logic toXram;
  logic toIram;
  logic [7:0] iramIdx;
  bilc_addr_decode u_dec (
    .dest(rec.addr),
    .toXram(toXram),
    .toIram(toIram),
    .iramIdx(iramIdx)
  );
  wire logic ctrlSel = (sfrAddr == BOOT_CONTROL_FLAGS_ADDR);
  wire logic ctrlWr = sfrWrEn && ctrlSel;
  wire logic loading = (state == ST_FACTORY) || (state == ST_USER);
  wire logic recTake = loading && recValid;
  // factory-only request outranks the user-continue setting
  wire logic factoryOnly = ctrl[BIT_FACTORY_ONLY] || stickyFactOnly;
  wire logic userAllowed = (bilc_level_t'(progLevel) != LVL_FACTORY) && !factoryOnly
    && (user_continue_setting || (bilc_level_t'(progLevel) == LVL_USER)
    || (bilc_level_t'(progLevel) == LVL_RUN));
  wire logic runReq = ctrl[BIT_RUN_SYS] || ctrl[BIT_RUN_POR];
  wire logic runHonoured = runReq && (bilc_level_t'(progLevel) != LVL_RUN);
  // the status byte itself is never overwritten by a record
  wire logic wantXram = recTake && toXram && (rec.addr != STATUS_ADDR);
  wire logic wantIram = recTake && toIram;
  assign recReady = loading;
  assign srcRewind = (state == ST_STRAP);
  assign imageEnd = (state == ST_DONE);
  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_STRAP: next_state = ST_FACTORY;
      ST_FACTORY: begin
        if (recTake && rec.lastInBlock) begin
          next_state = userAllowed ? ST_USER : ST_STATUS;
        end
      end
      ST_USER: begin
        // keep copying appended blocks until the image runs dry
        if (imageEmpty && !recValid) begin
          next_state = ST_STATUS;
        end
      end
      ST_STATUS: next_state = ST_DONE;
      ST_DONE: next_state = ST_DONE;
    endcase
  end
  // ***************************************************************
  // status byte update
  // ***************************************************************
  always_comb begin
    next_status = status;
    if (state == ST_STRAP) begin
      next_status = STAT_OK;
      next_status[STAT_STRAP] = strapSync;
    end else if (recTake && rec.err) begin
      if (state == ST_FACTORY) begin
        next_status[STAT_FACT_HI:STAT_FACT_LO] = FACT_ERR_CODE;
      end else if (firstBlock) begin
        next_status[STAT_USER_FIRST] = 1'b1;
      end else begin
        next_status[STAT_USER_NEXT] = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_STRAP;
      status <= STAT_OK;
      firstBlock <= 1'b1;
    end else begin
      state <= next_state;
      status <= next_status;
      if (state == ST_USER && recTake && rec.lastInBlock) begin
        firstBlock <= 1'b0;
      end
    end
  end
  // ***************************************************************
  // control register
  // ***************************************************************
  // only bits 5, 4, 2, 1 and 0 store; reserved bits stay zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= BOOT_CONTROL_FLAGS_RESET;
      stickyFactOnly <= 1'b0;
    end else begin
      if (ctrlWr) begin
        ctrl[BIT_RUN_SYS] <= sfrWrData[BIT_RUN_SYS];
        ctrl[BIT_RUN_POR] <= sfrWrData[BIT_RUN_POR];
        ctrl[BIT_FACTORY_ONLY] <= sfrWrData[BIT_FACTORY_ONLY];
        ctrl[BIT_FAIL] <= sfrWrData[BIT_FAIL];
        ctrl[BIT_DONE] <= sfrWrData[BIT_DONE];
        if (sfrWrData[BIT_FACTORY_ONLY]) begin
          stickyFactOnly <= 1'b1;
        end
      end
      // hardware set wins over a software write in the same cycle
      if (state == ST_STATUS) begin
        ctrl[BIT_DONE] <= 1'b1;
        if (status != STAT_OK) begin
          ctrl[BIT_FAIL] <= 1'b1;
        end
      end
    end
  end
  assign sfrRdData = (sfrRdEn && ctrlSel) ? ctrl : 8'h00;
  // ***************************************************************
  // destination writes
  // ***************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xramWrEn <= 1'b0;
      xramWr <= '0;
      iramWrEn <= 1'b0;
      iramAddr <= 8'h00;
      iramData <= 8'h00;
      cpuRelease <= 1'b0;
      cpuJump <= 1'b0;
      cpuJumpAddr <= RUN_ENTRY_ADDR;
    end else begin
      xramWrEn <= wantXram;
      iramWrEn <= wantIram;
      if (wantXram) begin
        xramWr <= '{addr: rec.addr, data: rec.data};
      end else if (state == ST_STATUS) begin
        // the status byte lands in the reserved top of RAM
        xramWrEn <= 1'b1;
        xramWr <= '{addr: STATUS_ADDR, data: status};
      end
      if (wantIram) begin
        iramAddr <= iramIdx;
        iramData <= rec.data;
      end
      cpuRelease <= (state == ST_DONE);
      cpuJump <= (state == ST_STATUS) && runHonoured;
      cpuJumpAddr <= RUN_ENTRY_ADDR;
    end
  end
  // ***************************************************************
  // checks
  // ***************************************************************
  chk_done_after: assert property (@(posedge clk) disable iff (!nrst)
    state == ST_STATUS |=> ctrl[BIT_DONE]) else $error("done flag not set");
  chk_fail_status: assert property (@(posedge clk) disable iff (!nrst)
    (state == ST_STATUS && status != STAT_OK) |=> ctrl[BIT_FAIL])
    else $error("fail flag missing");
  chk_jump_level: assert property (@(posedge clk) disable iff (!nrst)
    cpuJump |-> $past(bilc_level_t'(progLevel) != LVL_RUN))
    else $error("jump at run level");
  chk_jump_cause: assert property (@(posedge clk) disable iff (!nrst)
    cpuJump |-> $past(runReq)) else $error("jump without run bit");
  chk_iram_range: assert property (@(posedge clk) disable iff (!nrst)
    iramWrEn |-> (iramAddr >= IRAM_WR_LO[7:0] && iramAddr <= IRAM_WR_HI[7:0]))
    else $error("iram write outside window");
  chk_iram_map: assert property (@(posedge clk) disable iff (!nrst)
    wantIram |=> iramAddr == $past(rec.addr[7:0])) else $error("iram index wrong");
  chk_xram_range: assert property (@(posedge clk) disable iff (!nrst)
    xramWrEn |-> xramWr.addr <= XRAM_HI) else $error("xram write out of range");
  chk_factory_stop: assert property (@(posedge clk) disable iff (!nrst)
    factoryOnly |-> state != ST_USER || $past(state) == ST_USER)
    else $error("user load under factory-only");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl & ~(CTRL_WRITABLE_MASK | 8'h06)) == 8'h00)
    else $error("reserved bit set");
  chk_iram_data: assert property (@(posedge clk) disable iff (!nrst)
    wantIram |=> iramWrEn && iramData == $past(rec.data)) else $error("iram data lost");
  cov_user_load: cover property (@(posedge clk) disable iff (!nrst) state == ST_USER);
  cov_jump: cover property (@(posedge clk) disable iff (!nrst) cpuJump);
  cov_fail: cover property (@(posedge clk) disable iff (!nrst) ctrl[BIT_FAIL]);
  cov_iram: cover property (@(posedge clk) disable iff (!nrst) iramWrEn);
endmodule // bilc_loader

// file: hdl/bilc_pkg.sv
// package of constants and types for the boot image loader control
package bilc_pkg;
  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] BOOT_CONTROL_FLAGS_ADDR = 8'hDD;
  localparam logic [7:0] BOOT_CONTROL_FLAGS_RESET = 8'h00;
  localparam int BIT_RUN_SYS = 0;
  localparam int BIT_DONE = 1;
  localparam int BIT_FAIL = 2;
  localparam int BIT_RUN_POR = 4;
  localparam int BIT_FACTORY_ONLY = 5;
  localparam logic [7:0] CTRL_WRITABLE_MASK = 8'h31;
  // ***************************************************************
  // destination address map
  // ***************************************************************
  localparam logic [15:0] XRAM_LO = 16'h0000;
  localparam logic [15:0] XRAM_HI = 16'h11FF;
  localparam logic [15:0] IRAM_WIN_LO = 16'h7000;
  localparam logic [15:0] IRAM_WIN_HI = 16'h70FF;
  localparam logic [15:0] IRAM_WR_LO = 16'h7020;
  localparam logic [15:0] IRAM_WR_HI = 16'h70EF;
  localparam logic [15:0] STATUS_ADDR = 16'h11FF;
  localparam logic [15:0] RUN_ENTRY_ADDR = 16'h0000;
  // ***************************************************************
  // status byte layout
  // ***************************************************************
  localparam int STAT_STRAP = 7;
  localparam int STAT_FACT_HI = 4;
  localparam int STAT_FACT_LO = 2;
  localparam int STAT_USER_NEXT = 1;
  localparam int STAT_USER_FIRST = 0;
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [2:0] FACT_ERR_CODE = 3'h1;
  // program levels of the part
  typedef enum logic [1:0] {LVL_FACTORY, LVL_USER, LVL_RUN} bilc_level_t;
  // one record byte from the image source
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic factory;
    logic lastInBlock;
    logic err;
  } bilc_rec_t;
  // one write toward a destination memory
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } bilc_wr_t;
endpackage

// file: hdl/bilc_addr_decode.sv
// destination decoder that steers a record byte to RAM or window
`timescale 1ns/1ps
module bilc_addr_decode
  import bilc_pkg::*;
(
  input wire logic [15:0] dest,
  output logic toXram,
  output logic toIram,
  output logic [7:0] iramIdx
);
  // ***************************************************************
  // range checks
  // ***************************************************************
  // address checks only; the reserved status area is left to the caller
  wire logic inXram = (dest <= XRAM_HI);
  wire logic inWin = (dest >= IRAM_WIN_LO) && (dest <= IRAM_WIN_HI);
  wire logic winWritable = (dest >= IRAM_WR_LO) && (dest <= IRAM_WR_HI);
  assign toXram = inXram;
  // indirect path only, so sfr space is unreachable by construction
  assign toIram = inWin && winWritable;
  assign iramIdx = dest[7:0];
endmodule // bilc_addr_decode

// file: verification/bilc_nvm_model.sv
// image source model standing in for the nonvolatile memory
`timescale 1ns/1ps
module bilc_nvm_model
  import bilc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic stall,
  input wire logic recReady,
  output logic recValid,
  output bilc_rec_t rec,
  output logic imageEmpty
);
  // ***************************************************************
  // image store, filled by the bench before each boot
  // ***************************************************************
  bilc_rec_t img[$];
  int idx;
  logic [40:0] junk;
  wire logic take = recValid && recReady;
  // an idle bus shows a moving pattern so stale records cannot pass
  assign rec = recValid ? img[idx] : junk;
  assign imageEmpty = (idx >= img.size());
  // an offer holds until taken; stalls only fall between records
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx <= 0;
      recValid <= 1'b0;
      junk <= 41'h0A5C3;
    end else begin
      junk <= {junk[39:0], ~junk[40]};
      if (take) idx <= idx + 1;
      if (!recValid || take) recValid <= (idx + int'(take) < img.size()) && !stall;
    end
  end
endmodule // bilc_nvm_model

// file: verification/tb_boot_image_loader_control.sv
// self-checking bench for the boot image loader control
`timescale 1ns/1ps
module tb_boot_image_loader_control
  import bilc_pkg::*;
;
  logic clk, nrst, strapPin, ucont, sfrWrEn, sfrRdEn, stall;
  logic [1:0] progLevel;
  logic [7:0] sfrAddr, sfrWrData, iramAddr, iramData, sfrRdData;
  logic recValid, recReady, srcRewind, imageEnd, imageEmpty, xramWrEn, iramWrEn;
  logic cpuRelease, cpuJump;
  logic [15:0] cpuJumpAddr;
  bilc_rec_t rec;
  bilc_wr_t xramWr;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int jumps;
  logic [31:0] seed = 32'hB5653490;
  bilc_wr_t expX[$];
  bilc_wr_t expI[$];
  // ***************************************************************
  // boot cases: level, user-continue, control value, strap, errors
  // ***************************************************************
  logic [1:0] lv [5] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h3};
  logic uc [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0] ct [5] = '{8'h01, 8'hC8, 8'h30, 8'h11, 8'h10};
  logic st [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic er [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  // window edges and dropped places sit in the factory block
  logic [15:0] fa [8] = '{16'h0000, 16'h11FE, 16'h7020, 16'h70EF,
    16'h701F, 16'h70F0, 16'h11FF, 16'h8000};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  bilc_nvm_model nvm (.clk(clk), .nrst(nrst), .stall(stall), .recReady(recReady),
    .recValid(recValid), .rec(rec), .imageEmpty(imageEmpty));

  bilc_loader dut (.clk(clk), .nrst(nrst), .strapPin(strapPin), .progLevel(progLevel),
    .user_continue_setting(ucont), .recValid(recValid), .rec(rec), .recReady(recReady),
    .srcRewind(srcRewind), .imageEnd(imageEnd), .imageEmpty(imageEmpty),
    .xramWrEn(xramWrEn), .xramWr(xramWr), .iramWrEn(iramWrEn), .iramAddr(iramAddr),
    .iramData(iramData), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .cpuRelease(cpuRelease),
    .cpuJump(cpuJump), .cpuJumpAddr(cpuJumpAddr));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chkw(input string n, input bilc_wr_t e, input bilc_wr_t g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chkb(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // queue a record and note where it must land, if anywhere
  task automatic addRec(input logic [15:0] a, input logic f, input logic l, input logic e,
    input logic ld);
    bilc_rec_t r;
    r.addr = a;
    r.data = 8'(xs());
    r.factory = f;
    r.lastInBlock = l;
    r.err = e;
    nvm.img.push_back(r);
    if (ld && a <= 16'h11FE) expX.push_back('{a, r.data});
    else if (ld && a >= IRAM_WR_LO && a <= IRAM_WR_HI) expI.push_back('{a, r.data});
  endtask

  task automatic runCfg(input int i);
    logic ld;
    logic [7:0] stat;
    int j0;
    @(posedge clk);
    nrst <= 1'b0;
    progLevel <= lv[i];
    ucont <= uc[i];
    strapPin <= st[i];
    nvm.img.delete();
    expX.delete();
    expI.delete();
    j0 = jumps;
    // user load needs a programmed level; user-continue only matters off the known levels
    ld = (lv[i] != 2'h0) && (uc[i] || lv[i] != 2'h3) && !ct[i][BIT_FACTORY_ONLY];
    for (int k = 0; k < 8; k++) addRec(fa[k], 1'b1, k == 7, er[i] && k == 7, 1'b1);
    for (int b = 0; b < 2; b++) begin
      for (int k = 0; k < 3; k++) begin
        addRec(k == 0 ? 16'(xs() % 32'h11FF) : (k == 1 ? 16'h7056 : 16'h8000), 1'b0,
          k == 2, er[i] && k == 2, ld);
      end
    end
    stat = {st[i], 2'h0, er[i] ? FACT_ERR_CODE : 3'h0, er[i] && ld, er[i] && ld};
    expX.push_back('{STATUS_ADDR, stat});
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chkb("rewind", 16'h0001, 16'(srcRewind));
    @(posedge clk);
    #1 chkb("ctrlReset", 16'h0000, 16'(sfrRdData));
    @(posedge clk);
    sfrWrEn <= 1'b1;
    sfrWrData <= ct[i];
    @(posedge clk);
    sfrWrEn <= 1'b0;
    for (int k = 0; k < 500 && cpuRelease !== 1'b1; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    #1 chkb("pending", 16'h0000, 16'(expX.size() + expI.size()));
    chkb("ctrl", 16'((ct[i] & 8'h31) | 8'h02 | (stat != 8'h00 ? 8'h04 : 8'h00)),
      16'(sfrRdData));
    chkb("jumps", 16'((ct[i][0] | ct[i][4]) && lv[i] != 2'h2), 16'(jumps - j0));
    chkb("release", 16'h0001, 16'(cpuRelease & imageEnd));
    @(posedge clk);
    sfrAddr <= 8'hDC;
    @(posedge clk);
    #1 chkb("unmapped", 16'h0000, 16'(sfrRdData));
    @(posedge clk);
    sfrAddr <= 8'hDD;
  endtask

  // ***************************************************************
  // output watcher: each write strobe takes the oldest note
  // ***************************************************************
  always @(posedge clk) begin
    stall <= ^xs();
    cyc++;
    if (nrst && xramWrEn === 1'b1) begin
      if (expX.size() == 0) chkw("xramExtra", '0, xramWr);
      else chkw("xram", expX.pop_front(), xramWr);
    end
    if (nrst && iramWrEn === 1'b1) begin
      if (expI.size() == 0) chkw("iramExtra", '0, {8'h70, iramAddr, iramData});
      else chkw("iram", expI.pop_front(), {8'h70, iramAddr, iramData});
    end
    if (nrst && cpuJump === 1'b1) begin
      jumps++;
      chkb("jumpAddr", RUN_ENTRY_ADDR, cpuJumpAddr);
    end
    // ceiling far above five boots; a hang counts as a mismatch
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    nrst = 1'b0;
    strapPin = 1'b0;
    progLevel = 2'h0;
    ucont = 1'b0;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b1;
    sfrAddr = 8'hDD;
    sfrWrData = 8'h00;
    for (int i = 0; i < 5; i++) runCfg(i);
    print_verdict();
  end
endmodule // tb_boot_image_loader_control
